// *** logic/usb_rx_defines.svh ***
`ifndef USB_RX_DEFINES_SVH
`define USB_RX_DEFINES_SVH

`define RXC_HALF_W 16
`define RXC_UNIT_BIT 15
`define RXC_BLK_LSB 10
`define RXC_BLK_W 5
`define RXC_COUNT_MAX 11'h3FF
`define RXC_CNT_SAT 11'h7FF
`define RXC_SMALL_SHIFT 1
`define RXC_LARGE_SHIFT 5

`endif

// *** logic/usb_rx_pkg.sv ***
package usb_rx_pkg;

    typedef struct packed {
        logic unitSel;
        logic [4:0] blocks;
        logic [9:0] count;
    } size_count_s;

    typedef struct packed {
        size_count_s [1:0] entry;
        logic busy;
        logic sel;
        logic [10:0] byteCnt;
        logic [7:0] lowByte;
        logic ovf;
        logic memWe;
        logic [15:0] memAddr;
        logic [15:0] memData;
        logic done;
        logic ovfErr;
        logic [31:0] rdata;
    } state_s;

endpackage

// *** logic/rx_capacity_calc.sv ***
`timescale 1ns/1ps
`include "usb_rx_defines.svh"

module rx_capacity_calc (
    input wire logic clk,
    input wire logic sys_rst,
    input wire usb_rx_pkg::size_count_s entry,
    output logic [10:0] capacity
);

    // ----------------------------------------
    // Capacity from unit select and block count
    // ----------------------------------------
    // A zero block count with small units yields zero, so every byte overflows.
    logic [10:0] blocksWide;

    assign blocksWide = {6'h00, entry.blocks};

    always_comb begin
        if (entry.unitSel) begin
            capacity = 11'((blocksWide + 11'h001) << `RXC_LARGE_SHIFT);
        end else begin
            capacity = 11'(blocksWide << `RXC_SMALL_SHIFT);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_small_unit: assert property (@(posedge clk) disable iff (sys_rst)
        !entry.unitSel |-> capacity == 11'(entry.blocks * 2))
        else $error("Small unit capacity is not two bytes per block.");
    a_large_unit: assert property (@(posedge clk) disable iff (sys_rst)
        entry.unitSel |-> capacity == 11'((entry.blocks + 1) * 32))
        else $error("Large unit capacity is not (N+1)*32 bytes.");

endmodule

// *** logic/usb_rx_size_count.sv ***
`timescale 1ns/1ps
`include "usb_rx_defines.svh"

module usb_rx_size_count #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic swWe,
    input wire logic [1:0] swBe,
    input wire logic [31:0] swWdata,
    output logic [31:0] swRdata,
    input wire logic [15:0] rxBufferStart0,
    input wire logic [15:0] rxBufferStart1,
    input wire logic rxStart,
    input wire logic rxBufSel,
    input wire logic rxByteValid,
    input wire logic [7:0] rxByte,
    input wire logic rxEnd,
    output logic memWe,
    output logic [15:0] memAddr,
    output logic [15:0] memData,
    output logic rxBusy,
    output logic rxDone,
    output logic overflowErr
);

    if (ADDR_W != 16) begin : g_bad_addr
        $error("Packet memory addresses are sixteen bits wide.");
    end

    usb_rx_pkg::state_s q;
    usb_rx_pkg::state_s d;
    logic [10:0] capacity;
    logic [15:0] base;
    logic [15:0] wordAddr;
    logic [9:0] endCount;

    // ----------------------------------------
    // Capacity of the buffer being filled
    // ----------------------------------------
    rx_capacity_calc u_cap (
        .clk(clk),
        .sys_rst(sys_rst),
        .entry(q.entry[q.sel]),
        .capacity(capacity)
    );

    // Bit 0 of the start address is forced low; a stray one cannot misalign words.
    assign base = (q.sel ? rxBufferStart1 : rxBufferStart0) & 16'hFFFE;
    assign wordAddr = 16'(base + {5'h00, q.byteCnt[10:1], 1'b0});
    assign endCount = (q.byteCnt > `RXC_COUNT_MAX) ? 10'h3FF : q.byteCnt[9:0];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        d.memWe = 1'b0;
        d.done = 1'b0;
        d.ovfErr = 1'b0;
        d.rdata = q.entry;
        if (swWe) begin
            for (int h = 0; h < 2; h++) begin
                if (swBe[h]) begin
                    // Only the allocation fields take software data.
                    d.entry[h].unitSel = swWdata[h * `RXC_HALF_W + `RXC_UNIT_BIT];
                    d.entry[h].blocks =
                        swWdata[h * `RXC_HALF_W + `RXC_BLK_LSB +: `RXC_BLK_W];
                end
            end
        end
        if (!q.busy) begin
            if (rxStart) begin
                d.busy = 1'b1;
                d.sel = rxBufSel;
                d.byteCnt = 11'h000;
                d.ovf = 1'b0;
            end
        end else if (rxEnd) begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.entry[q.sel].count = endCount;
            d.ovfErr = q.ovf;
            if (q.byteCnt[0] && q.byteCnt <= capacity) begin
                d.memWe = 1'b1;
                d.memAddr = wordAddr;
                d.memData = {8'h00, q.lowByte};
            end
        end else if (rxByteValid) begin
            if (q.byteCnt < capacity) begin
                if (!q.byteCnt[0]) begin
                    d.lowByte = rxByte;
                end else begin
                    d.memWe = 1'b1;
                    d.memAddr = wordAddr;
                    d.memData = {rxByte, q.lowByte};
                end
            end else begin
                d.ovf = 1'b1;
            end
            if (q.byteCnt != `RXC_CNT_SAT) begin
                d.byteCnt = 11'(q.byteCnt + 11'h001);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign swRdata = q.rdata;
    assign memWe = q.memWe;
    assign memAddr = q.memAddr;
    assign memData = q.memData;
    assign rxBusy = q.busy;
    assign rxDone = q.done;
    assign overflowErr = q.ovfErr;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_count_writeback: assert property (
        q.busy && rxEnd |=> q.entry[$past(q.sel)].count == $past(endCount) && q.done)
        else $error("Received count not written back at end of reception.");
    a_sw_readonly: assert property (
        swWe && !(q.busy && rxEnd) |=> $stable(q.entry[0].count) && $stable(q.entry[1].count))
        else $error("Software write changed a received count.");
    a_sw_blocks: assert property (
        swWe && swBe[1] |=> q.entry[1].blocks == $past(swWdata[30:26])
            && q.entry[1].unitSel == $past(swWdata[31]))
        else $error("Upper allocation fields did not take the write.");
    a_other_half: assert property (
        q.busy && rxEnd && !q.sel |=> $stable(q.entry[1].count))
        else $error("Writeback touched the other buffer half.");
    a_addr_aligned: assert property (
        memWe |-> !memAddr[0])
        else $error("Packet memory write is not word aligned.");
    a_no_write_beyond: assert property (
        q.busy && !rxEnd && rxByteValid && q.byteCnt >= capacity |=> !memWe ##1 q.ovf)
        else $error("Byte beyond capacity was written.");
    a_ovf_reported: assert property (
        q.busy && rxEnd && q.byteCnt > capacity |=> overflowErr && rxDone)
        else $error("Overflow not reported at end of reception.");
    a_rdata_view: assert property (
        1'b1 |=> swRdata == $past(q.entry))
        else $error("Read view does not show both halves.");

    c_overflow: cover property (q.busy && rxEnd && q.ovf);
    c_buffer1: cover property (q.busy && rxEnd && q.sel);
    c_odd_flush: cover property (q.busy && rxEnd && q.byteCnt[0] ##1 memWe);

endmodule

// *** verif/usb_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the OUT and SETUP data stage.
// ----------------------------------------
module usb_host_model (
    input wire logic clk,
    output logic rxStart,
    output logic rxBufSel,
    output logic rxByteValid,
    output logic [7:0] rxByte,
    output logic rxEnd
);
    initial begin
        {rxStart, rxBufSel, rxByteValid, rxEnd} = 4'h0;
        rxByte = 8'hA5;
    end
    // Byte k carries k; between packets the line is inverted so stale data is never trusted.
    task automatic send(input logic sel, input int n);
        @(posedge clk);
        rxStart <= 1'b1;
        rxBufSel <= sel;
        for (int k = 1; k <= n; k++) begin
            @(posedge clk);
            rxStart <= 1'b0;
            rxByteValid <= 1'b1;
            rxByte <= 8'(k);
        end
        @(posedge clk);
        rxByteValid <= 1'b0;
        rxByte <= ~rxByte;
        rxEnd <= 1'b1;
        @(posedge clk);
        rxEnd <= 1'b0;
    endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
// ----------------------------------------
// Bench top.
// ----------------------------------------
module testbench;
    logic clk, sysRst, swWe, memWe, rxBusy, rxDone, overflowErr, ovfSeen;
    logic rxStart, rxBufSel, rxByteValid, rxEnd;
    logic [1:0] swBe;
    logic [7:0] rxByte;
    logic [15:0] memAddr, memData, firstA, lastA, lastD;
    logic [31:0] swWdata, swRdata, exp;
    int n_errors = 0;
    int num_checks = 0;
    int nWr = 0;
    int nBusy = 0;
    int cycles = 0;
    usb_rx_size_count u_dut (.clk, .sys_rst(sysRst), .swWe, .swBe, .swWdata, .swRdata,
        .rxBufferStart0(16'h0101), .rxBufferStart1(16'h0400), .rxStart, .rxBufSel,
        .rxByteValid, .rxByte, .rxEnd, .memWe, .memAddr, .memData, .rxBusy, .rxDone,
        .overflowErr);
    usb_host_model u_host (.clk, .rxStart, .rxBufSel, .rxByteValid, .rxByte, .rxEnd);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // An odd start address is fed to buffer 0 on purpose; the word alignment must drop bit 0.
    // The tallies restart when the host starts a packet, so only this process writes them.
    always @(posedge clk) begin
        cycles++;
        if (rxStart) begin
            nWr = 0;
            nBusy = 0;
            ovfSeen = 1'bx;
        end
        if (rxBusy) nBusy++;
        if (memWe) begin
            if (nWr == 0) firstA = memAddr;
            lastA = memAddr;
            lastD = memData;
            nWr++;
        end
        if (rxDone) ovfSeen = overflowErr;
        if (cycles == 5000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] be, input logic [31:0] d);
        @(posedge clk);
        swWe <= 1'b1;
        swBe <= be;
        swWdata <= d;
        if (be[0]) exp[15:10] = d[15:10];
        if (be[1]) exp[31:26] = d[31:26];
        @(posedge clk);
        swWe <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("readback", exp, swRdata)
    endtask
    task automatic rx(input logic [15:0] c, input logic sel, input int n);
        int cap, m;
        cap = c[15] ? (int'(c[14:10]) + 1) * 32 : 2 * int'(c[14:10]);
        m = n < cap ? n : cap;
        wr(sel ? 2'b10 : 2'b01, {c, c});
        u_host.send(sel, n);
        repeat (3) @(posedge clk);
        exp[sel * 16 +: 10] = n > 1023 ? 10'h3FF : 10'(n);
        `CHK("writes", (m + 1) / 2, nWr)
        `CHK("first address", sel ? 16'h0400 : 16'h0100, firstA)
        `CHK("last address", (sel ? 16'h0400 : 16'h0100) + 16'((m - 1) / 2 * 2), lastA)
        `CHK("busy cycles", n + 1, nBusy)
        `CHK("last word", m[0] ? {8'h00, 8'(m)} : {8'(m), 8'(m - 1)}, lastD)
        `CHK("overflow", logic'(n > cap), ovfSeen)
        `CHK("entry", exp, swRdata)
        $display("reception test done, %0d bytes", n);
    endtask
    initial begin
        {sysRst, swWe, swBe, swWdata, exp} = {1'b1, 35'h0, 32'h0};
        repeat (4) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        `CHK("reset value", 32'h0, swRdata)
        wr(2'b11, 32'hFFFF_FFFF);
        $display("reset and register test done");
        rx(16'h0800, 1'b0, 3);
        rx(16'h0800, 1'b0, 5);
        rx(16'h7C00, 1'b0, 63);
        rx(16'h8000, 1'b1, 33);
        rx(16'h8000, 1'b1, 32);
        rx(16'hFC00, 1'b1, 1025);
        rx(16'h0400, 1'b0, 2);
        results();
    end
endmodule
